// ===== design/dma_pkg.sv
// data memory addressing package: map offsets, field positions, reset values
// assumes: used by the addressing core and its checker, cpu model and testbench, no imports
package dma_pkg;
    // special register offsets, all in sector 0 except eeprom control in sector 1
    localparam logic [7:0] OFS_INDIRECT_PORT_0 = 8'h00;
    localparam logic [7:0] OFS_POINTER_0 = 8'h01;
    localparam logic [7:0] OFS_INDIRECT_PORT_1 = 8'h02;
    localparam logic [7:0] OFS_POINTER_1_LOW = 8'h03;
    localparam logic [7:0] OFS_POINTER_1_HIGH = 8'h04;
    localparam logic [7:0] OFS_ACCUMULATOR = 8'h05;
    localparam logic [7:0] OFS_PROG_COUNTER_LOW = 8'h06;
    localparam logic [7:0] OFS_INDIRECT_PORT_2 = 8'h0c;
    localparam logic [7:0] OFS_POINTER_2_LOW = 8'h0d;
    localparam logic [7:0] OFS_POINTER_2_HIGH = 8'h0e;
    localparam logic [7:0] OFS_EEPROM_CONTROL = 8'h40;
    // own status word: read-only view of pc and jump state
    localparam logic [7:0] OFS_PC_HIGH_STATUS = 8'h0b;
    localparam logic [7:0] OFS_RO_MASK = 8'h0f;
    // area split within a sector
    localparam logic [7:0] SPR_LAST = 8'h7f;
    localparam logic [7:0] GPR_FIRST = 8'h80;
    localparam int GPR_DEPTH = 128;
    localparam int SECTORS = 2;
    localparam int PC_WIDTH = 12;
    localparam int SECTOR_BIT = 0;
    localparam int PCH_BIT_LSB = 8;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [PC_WIDTH-1:0] RST_PC = 12'h000;
    localparam logic [7:0] RST_RO_MASK = 8'h00;
    // avalon side: byte address = 4 * location index
    localparam int AV_ADDR_W = 11;
    typedef struct packed {
        logic read;
        logic write;
        logic [AV_ADDR_W-1:0] address;
        logic [31:0] writedata;
    } dma_req_t;
    // cpu datapath access: 9-bit address, op kind, bit number
    typedef enum logic [1:0] {DMA_OP_BYTE, DMA_OP_SETBIT, DMA_OP_CLRBIT, DMA_OP_FROMACC} dma_op_t;
    typedef struct packed {
        logic valid;
        logic write;
        dma_op_t op;
        logic [2:0] bit_sel;
        logic [8:0] addr;
        logic [7:0] wdata;
    } dma_cpu_t;
endpackage

// ===== design/dma_core.sv
// data memory addressing core: sectors, pointers, indirect ports, pc low
// assumes: cpu datapath on ref_clk, avalon master on ref_clk, one access at a time
`timescale 1ns/10ps
`default_nettype none
module dma_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [10:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire dma_pkg::dma_cpu_t cpu_req,
    input wire logic [7:0] alu_result,
    input wire logic alu_result_valid,
    input wire logic pc_advance,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic [7:0] accumulator_out,
    output logic [11:0] prog_counter,
    output logic dummy_cycle,
    output logic [7:0] eeprom_control_out
);
    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] pointer_0_ff;
    logic [7:0] pointer_1_low_ff;
    logic [7:0] pointer_1_high_ff;
    logic [7:0] pointer_2_low_ff;
    logic [7:0] pointer_2_high_ff;
    logic [7:0] accumulator_ff;
    logic [7:0] eeprom_control_ff;
    logic [7:0] ro_mask_ff;
    logic [11:0] pc_ff;
    logic dummy_ff;
    logic [7:0] gpr_mem [dma_pkg::SECTORS*dma_pkg::GPR_DEPTH];
    logic [7:0] cpu_rdata_ff;
    logic cpu_rvalid_ff;
    logic [31:0] av_rdata_ff;
    logic av_ack_ff;
    logic av_wait_ff;

    ////////////////////////////////////////////////////////////////////////
    // access arbitration: cpu wins, avalon waits until a cycle with no cpu access
    // the datapath cannot stall, so the bus is the side that yields
    // a bus request held across a busy datapath stretch is simply retried
    // limitation: a datapath that never idles starves the bus master
    // av_ack_ff masks the request in the answer cycle so a held strobe
    // is not taken twice before the master has seen waitrequest low
    logic av_req;
    logic av_go;
    logic acc_valid;
    logic acc_write;
    dma_pkg::dma_op_t acc_op;
    logic [2:0] acc_bit;
    logic [8:0] acc_addr;
    logic [7:0] acc_wdata;

    assign av_req = (avs_read | avs_write) & ~av_ack_ff;
    assign av_go = av_req & ~cpu_req.valid;

    // one access port into the map; avalon word index = 9-bit location
    always_comb begin
        if (cpu_req.valid) begin
            acc_valid = 1'b1;
            acc_write = cpu_req.write;
            acc_op = cpu_req.op;
            acc_bit = cpu_req.bit_sel;
            acc_addr = cpu_req.addr;
            acc_wdata = cpu_req.write && cpu_req.op == dma_pkg::DMA_OP_FROMACC ? accumulator_ff
                                                                                : cpu_req.wdata;
        end else begin
            acc_valid = av_go;
            acc_write = avs_write & avs_byteenable[0];
            acc_op = dma_pkg::DMA_OP_BYTE;
            acc_bit = 3'h0;
            acc_addr = avs_address[10:2];
            acc_wdata = avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indirect redirection: sector comes only from pointers or the address
    // only sector 0 holds the ports, so a sector 1 address skips the decode
    // port 0 has one pointer byte, so its sector is forced to 0
    // ports 1 and 2 take the sector from bit 0 of their high pointer;
    // the other high bits are kept as storage but do not steer anything
    // no bank register exists, so nothing else can pick the sector
    logic [8:0] eff_addr;
    logic port_hit;
    always_comb begin
        eff_addr = acc_addr;
        port_hit = 1'b0;
        if (acc_addr[8] == 1'b0) begin
            case (acc_addr[7:0])
                dma_pkg::OFS_INDIRECT_PORT_0: begin
                    eff_addr = {1'b0, pointer_0_ff};
                    port_hit = 1'b1;
                end
                dma_pkg::OFS_INDIRECT_PORT_1: begin
                    eff_addr = {pointer_1_high_ff[dma_pkg::SECTOR_BIT], pointer_1_low_ff};
                    port_hit = 1'b1;
                end
                dma_pkg::OFS_INDIRECT_PORT_2: begin
                    eff_addr = {pointer_2_high_ff[dma_pkg::SECTOR_BIT], pointer_2_low_ff};
                    port_hit = 1'b1;
                end
                default: begin
                    eff_addr = acc_addr;
                    port_hit = 1'b0;
                end
            endcase
        end
    end

    // a pointer that names a port again lands on the port: no storage there
    logic eff_is_port;
    logic eff_is_gpr;
    logic [7:0] gpr_idx;
    assign eff_is_port = ~eff_addr[8] && (eff_addr[7:0] == dma_pkg::OFS_INDIRECT_PORT_0
        || eff_addr[7:0] == dma_pkg::OFS_INDIRECT_PORT_1 || eff_addr[7:0] == dma_pkg::OFS_INDIRECT_PORT_2);
    assign eff_is_gpr = eff_addr[7:0] >= dma_pkg::GPR_FIRST;
    assign gpr_idx = {eff_addr[8], eff_addr[6:0]};

    ////////////////////////////////////////////////////////////////////////
    // read mux
    // default is zero so every unmapped location reads back 00H
    // ports fall to zero as well: they have no storage behind them
    // sector 1 specials only answer at the eeprom control location
    // trade-off: one shared mux keeps bus and datapath views identical
    logic [7:0] rd_val;
    always_comb begin
        rd_val = dma_pkg::READ_ZERO;
        if (eff_is_gpr) begin
            rd_val = gpr_mem[gpr_idx];
        end else if (eff_is_port) begin
            rd_val = dma_pkg::READ_ZERO;
        end else if (eff_addr[8]) begin
            if (eff_addr[7:0] == dma_pkg::OFS_EEPROM_CONTROL) begin
                rd_val = eeprom_control_ff;
            end
        end else begin
            case (eff_addr[7:0])
                dma_pkg::OFS_POINTER_0: rd_val = pointer_0_ff;
                dma_pkg::OFS_POINTER_1_LOW: rd_val = pointer_1_low_ff;
                dma_pkg::OFS_POINTER_1_HIGH: rd_val = pointer_1_high_ff;
                dma_pkg::OFS_POINTER_2_LOW: rd_val = pointer_2_low_ff;
                dma_pkg::OFS_POINTER_2_HIGH: rd_val = pointer_2_high_ff;
                dma_pkg::OFS_ACCUMULATOR: rd_val = accumulator_ff;
                dma_pkg::OFS_PROG_COUNTER_LOW: rd_val = pc_ff[7:0];
                dma_pkg::OFS_PC_HIGH_STATUS: rd_val = {3'h0, dummy_ff, pc_ff[11:8]};
                dma_pkg::OFS_RO_MASK: rd_val = ro_mask_ff;
                default: rd_val = dma_pkg::READ_ZERO;
            endcase
        end
    end

    // bit operations merge into the read value so other bits stay put
    logic [7:0] wr_val;
    always_comb begin
        case (acc_op)
            dma_pkg::DMA_OP_SETBIT: wr_val = rd_val | (8'h01 << acc_bit);
            dma_pkg::DMA_OP_CLRBIT: wr_val = rd_val & ~(8'h01 << acc_bit);
            default: wr_val = acc_wdata;
        endcase
    end

    // write qualifiers
    // a write that lands on a port after redirection is dropped here
    // sfr_wr covers sector 0 specials only; sector 1 is handled apart
    // general ram writes go through eff_is_gpr in both sectors
    logic do_wr;
    logic sfr_wr;
    assign do_wr = acc_valid & acc_write & ~eff_is_port;
    assign sfr_wr = do_wr & ~eff_is_gpr & ~eff_addr[8];

    ////////////////////////////////////////////////////////////////////////
    // general ram, both sectors
    // not reset: software must initialise it before use
    // one write port; reads are combinational from the same array
    // bit operations arrive here already merged with the old byte
    always_ff @(posedge ref_clk) begin
        if (do_wr && eff_is_gpr) begin
            gpr_mem[gpr_idx] <= wr_val;
        end
    end

    // pointer storage, plain read/write so inc and friends work
    // any register op may touch them, bit ops included
    // writes through a port never reach here: eff_addr is the pointed spot
    // unless a pointer itself is the target of the redirection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pointer_0_ff <= dma_pkg::RST_BYTE;
            pointer_1_low_ff <= dma_pkg::RST_BYTE;
            pointer_1_high_ff <= dma_pkg::RST_BYTE;
            pointer_2_low_ff <= dma_pkg::RST_BYTE;
            pointer_2_high_ff <= dma_pkg::RST_BYTE;
        end else if (sfr_wr) begin
            case (eff_addr[7:0])
                dma_pkg::OFS_POINTER_0: pointer_0_ff <= wr_val;
                dma_pkg::OFS_POINTER_1_LOW: pointer_1_low_ff <= wr_val;
                dma_pkg::OFS_POINTER_1_HIGH: pointer_1_high_ff <= wr_val;
                dma_pkg::OFS_POINTER_2_LOW: pointer_2_low_ff <= wr_val;
                dma_pkg::OFS_POINTER_2_HIGH: pointer_2_high_ff <= wr_val;
                default: pointer_0_ff <= pointer_0_ff;
            endcase
        end
    end

    // accumulator: alu result takes priority over a register write
    // both in one cycle would be a datapath fault; the alu wins
    // so that the result of the running instruction is never lost
    // register to register moves pass through here as two accesses
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accumulator_ff <= dma_pkg::RST_BYTE;
        end else if (alu_result_valid) begin
            accumulator_ff <= alu_result;
        end else if (sfr_wr && eff_addr[7:0] == dma_pkg::OFS_ACCUMULATOR) begin
            accumulator_ff <= wr_val;
        end
    end

    // read-only mask for eeprom control; set bits are protected from writes
    // mask resets to zero, so all control bits start writable
    // limitation: the mask itself is freely writable by software
    // it stands for the hardware-owned bits of the control register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ro_mask_ff <= dma_pkg::RST_RO_MASK;
        end else if (sfr_wr && eff_addr[7:0] == dma_pkg::OFS_RO_MASK) begin
            ro_mask_ff <= wr_val;
        end
    end

    // the only sector 1 special register
    // protected bits keep their old value, the rest take the write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eeprom_control_ff <= dma_pkg::RST_BYTE;
        end else if (do_wr && eff_addr[8] && eff_addr[7:0] == dma_pkg::OFS_EEPROM_CONTROL) begin
            eeprom_control_ff <= (wr_val & ~ro_mask_ff) | (eeprom_control_ff & ro_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter: pc low write jumps within the page, then one dummy
    // only the low byte is loaded; the page bits stay where they are
    // the jump beats a pending advance in the same cycle
    // the advance is held off during the dummy cycle so the
    // freshly loaded target is not skipped
    // pc wraps at the top of program memory
    logic pcl_wr;
    assign pcl_wr = sfr_wr && eff_addr[7:0] == dma_pkg::OFS_PROG_COUNTER_LOW;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_ff <= dma_pkg::RST_PC;
        end else if (pcl_wr) begin
            pc_ff <= {pc_ff[11:dma_pkg::PCH_BIT_LSB], wr_val};
        end else if (pc_advance && !dummy_ff) begin
            pc_ff <= pc_ff + 12'h001;
        end
    end

    // dummy cycle flag stalls the fetch for exactly one cycle
    // a second pc low write right behind the first restarts the stall
    // the flag is also visible at the read-only status word
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dummy_ff <= 1'b0;
        end else begin
            dummy_ff <= pcl_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answers
    // read data is registered, so it stands one cycle after the access
    // rvalid pulses once for every datapath read
    // the data byte is kept until the next read replaces it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cpu_rdata_ff <= dma_pkg::RST_BYTE;
            cpu_rvalid_ff <= 1'b0;
        end else begin
            cpu_rvalid_ff <= cpu_req.valid & ~cpu_req.write;
            if (cpu_req.valid && !cpu_req.write) begin
                cpu_rdata_ff <= rd_val;
            end
        end
    end

    // avalon: waitrequest high until the cycle after the access is done
    // waitrequest has its own flop so the pin comes straight from a register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            av_ack_ff <= 1'b0;
            av_wait_ff <= 1'b1;
            av_rdata_ff <= 32'h0000_0000;
        end else begin
            av_ack_ff <= av_go;
            av_wait_ff <= ~av_go;
            if (av_go) begin
                av_rdata_ff <= {24'h00_0000, rd_val};
            end
        end
    end

    assign avs_waitrequest = av_wait_ff;
    assign avs_readdata = av_rdata_ff;
    assign cpu_rdata = cpu_rdata_ff;
    assign cpu_rvalid = cpu_rvalid_ff;
    assign accumulator_out = accumulator_ff;
    assign prog_counter = pc_ff;
    assign dummy_cycle = dummy_ff;
    assign eeprom_control_out = eeprom_control_ff;
endmodule
`default_nettype wire

// ===== dv/dma_core_props.sv
// checker: port assertions for the data memory addressing core
// assumes: bound to dma_core, one clock ref_clk, sys_rst synchronous
`timescale 1ns/10ps
`default_nettype none
module dma_core_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [10:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dma_pkg::dma_cpu_t cpu_req,
    input wire logic [7:0] alu_result,
    input wire logic alu_result_valid,
    input wire logic cpu_rvalid,
    input wire logic [7:0] accumulator_out,
    input wire logic [11:0] prog_counter,
    input wire logic dummy_cycle
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////
// decoded views of the two request paths
wire logic [8:0] idx;
wire logic pcl_wr;
wire logic ack_rd;
assign idx = avs_address[10:2];
assign ack_rd = avs_read && !avs_waitrequest;
assign pcl_wr = cpu_req.valid && cpu_req.write && cpu_req.op == dma_pkg::DMA_OP_BYTE && cpu_req.addr == 9'h006;
////////////////////////////////////////////////////////////////
property p_pcl_load;
    pcl_wr |=> prog_counter == {$past(prog_counter[11:8]), $past(cpu_req.wdata)};
endproperty
a_pcl_load: assert property (p_pcl_load)
    else $error("pc low load wrong");
property p_pcl_dummy;
    pcl_wr ##1 !pcl_wr |-> dummy_cycle ##1 !dummy_cycle;
endproperty
a_pcl_dummy: assert property (p_pcl_dummy)
    else $error("dummy cycle missing or long");
property p_dummy_hold;
    dummy_cycle && !pcl_wr |=> $stable(prog_counter);
endproperty
a_dummy_hold: assert property (p_dummy_hold)
    else $error("pc moved in dummy cycle");
property p_acc_alu;
    alu_result_valid |=> accumulator_out == $past(alu_result);
endproperty
a_acc_alu: assert property (p_acc_alu)
    else $error("alu result not in accumulator");
property p_rvalid;
    cpu_req.valid && !cpu_req.write |=> cpu_rvalid;
endproperty
a_rvalid: assert property (p_rvalid)
    else $error("cpu read not answered");
property p_unused;
    ack_rd && !idx[8] && idx[7:0] inside {[8'h70:8'h7f]} |-> avs_readdata == 32'h0000_0000;
endproperty
a_unused: assert property (p_unused)
    else $error("unused location not zero");
property p_sect1;
    ack_rd && idx[8] && !idx[7] && idx[7:0] != 8'h40 |-> avs_readdata == 32'h0000_0000;
endproperty
a_sect1: assert property (p_sect1)
    else $error("sector 1 special not zero");
property p_upper;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
endproperty
a_upper: assert property (p_upper)
    else $error("read data wider than a byte");
endmodule
bind dma_core dma_core_props chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .alu_result(alu_result),
    .alu_result_valid(alu_result_valid), .cpu_rvalid(cpu_rvalid),
    .accumulator_out(accumulator_out), .prog_counter(prog_counter), .dummy_cycle(dummy_cycle));
`default_nettype wire

// ===== dv/dma_cpu_model.sv
// partner: instruction datapath issuing accesses, alu results, pc steps
// assumes: one access at a time, driven right after ref_clk edges
`timescale 1ns/10ps
`default_nettype none
module dma_cpu_model (
    input wire logic ref_clk,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid,
    output var dma_pkg::dma_cpu_t cpu_req,
    output logic [7:0] alu_result,
    output logic alu_result_valid,
    output logic pc_advance
);
// quiet datapath at time zero
initial begin
    cpu_req = '0;
    alu_result = 8'h00;
    alu_result_valid = 1'b0;
    pc_advance = 1'b0;
end
////////////////////////////////////////////////////////////////
// one access; idle data flips so stale values never look valid
task automatic access(input logic wr, input dma_pkg::dma_op_t op, input logic [2:0] b, input logic [8:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    cpu_req <= '{valid:1'b1, write:wr, op:op, bit_sel:b, addr:a, wdata:wd};
    @(posedge ref_clk);
    cpu_req.valid <= 1'b0;
    cpu_req.wdata <= ~wd;
    @(posedge ref_clk);
    rd = (cpu_rvalid === 1'b1) ? cpu_rdata : 8'hxx;
endtask
// alu result offered for one edge
task automatic alu(input logic [7:0] v);
    alu_result <= v;
    alu_result_valid <= 1'b1;
    @(posedge ref_clk);
    alu_result_valid <= 1'b0;
    alu_result <= ~v;
    @(posedge ref_clk);
endtask
// n program counter steps
task automatic advance(input int n);
    pc_advance <= 1'b1;
    repeat (n) @(posedge ref_clk);
    pc_advance <= 1'b0;
    @(posedge ref_clk);
endtask
endmodule
`default_nettype wire

// ===== dv/tb_data_memory_addressing.sv
// testbench: register bus and datapath scenarios for the addressing core
// assumes: dma_core checker bound in, cpu partner model, 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb_data_memory_addressing;
logic ref_clk = 1'b0;
logic sys_rst = 1'b1;
logic [10:0] avs_address = 11'h000;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = 32'h0000_0000;
logic [3:0] avs_byteenable = 4'h0;
logic [31:0] avs_readdata;
logic avs_waitrequest;
dma_pkg::dma_cpu_t cpu_req;
logic [7:0] alu_result, cpu_rdata, accumulator_out, eeprom_control_out, rd, v;
logic alu_result_valid, pc_advance, cpu_rvalid, dummy_cycle;
logic [11:0] prog_counter;
logic [8:0] ix;
logic [8:0] zl [10] = '{9'h001, 9'h003, 9'h004, 9'h00d, 9'h00e, 9'h005, 9'h140, 9'h07f, 9'h022, 9'h141};
int error_cnt = 0;
int checks = 0;
int cyc = 0;
int seed = 92;
always #12.5 ref_clk = ~ref_clk;
dma_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req),
    .alu_result(alu_result), .alu_result_valid(alu_result_valid), .pc_advance(pc_advance),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .accumulator_out(accumulator_out),
    .prog_counter(prog_counter), .dummy_cycle(dummy_cycle), .eeprom_control_out(eeprom_control_out));
dma_cpu_model cpu_u (.ref_clk(ref_clk), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_req(cpu_req),
    .alu_result(alu_result), .alu_result_valid(alu_result_valid), .pc_advance(pc_advance));
////////////////////////////////////////////////////////////////
task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
endtask
// bus cycle: request held until waitrequest is sampled low
task automatic av(input logic wr, input logic [8:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= {a, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 64) begin
        @(posedge ref_clk);
        n++;
    end
    if (n == 64)
        error_cnt++;
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
    @(posedge ref_clk);
endtask
task automatic rdchk(input string nm, input logic [8:0] a, input logic [7:0] e);
    av(1'b0, a, 8'h00, 4'h1);
    chk(nm, {4'h0, e}, {4'h0, rd});
endtask
////////////////////////////////////////////////////////////////
// hang guard, well above the few hundred cycles needed
always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        error_cnt = error_cnt + 1;
        end_of_test();
    end
end
////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    foreach (zl[i]) rdchk("zero", zl[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
        v = $random(seed);
        av(1'b1, zl[i], v, 4'h1);
        rdchk("pointer", zl[i], v);
    end
    $display("test reset and pointers done");
    // general ram in both sectors, cpu and bus, refused lane
    for (int i = 0; i < 8; i++) begin
        ix = $random(seed);
        ix[7] = 1'b1;
        v = $random(seed);
        cpu_u.access(1'b1, dma_pkg::DMA_OP_BYTE, 3'h0, ix, v, rd);
        rdchk("gpr", ix, v);
        av(1'b1, ix, ~v, 4'h1);
        av(1'b1, ix, v, 4'he);
        cpu_u.access(1'b0, dma_pkg::DMA_OP_BYTE, 3'h0, ix, 8'h00, rd);
        chk("cpu_gpr", {4'h0, ~v}, {4'h0, rd});
    end
    $display("test general ram done");
    // indirect ports through their pointers
    av(1'b1, 9'h004, 8'h03, 4'h1);
    av(1'b1, 9'h003, 8'h90, 4'h1);
    cpu_u.access(1'b1, dma_pkg::DMA_OP_BYTE, 3'h0, 9'h002, 8'ha5, rd);
    rdchk("port1", 9'h190, 8'ha5);
    av(1'b1, 9'h00e, 8'h02, 4'h1);
    av(1'b1, 9'h0b0, 8'h3c, 4'h1);
    av(1'b1, 9'h00d, 8'hb0, 4'h1);
    cpu_u.access(1'b0, dma_pkg::DMA_OP_BYTE, 3'h0, 9'h00c, 8'h00, rd);
    chk("port2", 12'h03c, {4'h0, rd});
    av(1'b1, 9'h1c5, 8'h11, 4'h1);
    av(1'b1, 9'h0c5, 8'h22, 4'h1);
    av(1'b1, 9'h001, 8'hc5, 4'h1);
    cpu_u.access(1'b0, dma_pkg::DMA_OP_BYTE, 3'h0, 9'h000, 8'h00, rd);
    chk("port0", 12'h022, {4'h0, rd});
    av(1'b1, 9'h001, 8'h02, 4'h1);
    cpu_u.access(1'b0, dma_pkg::DMA_OP_BYTE, 3'h0, 9'h000, 8'h00, rd);
    chk("port_self", 12'h000, {4'h0, rd});
    $display("test indirect done");
    // single bit changes, then a protected control field
    av(1'b1, 9'h1a0, 8'h5a, 4'h1);
    cpu_u.access(1'b1, dma_pkg::DMA_OP_SETBIT, 3'h7, 9'h1a0, 8'h00, rd);
    cpu_u.access(1'b1, dma_pkg::DMA_OP_CLRBIT, 3'h1, 9'h1a0, 8'hff, rd);
    rdchk("bitop", 9'h1a0, 8'hd8);
    av(1'b1, 9'h00f, 8'hf0, 4'h1);
    av(1'b1, 9'h140, 8'hff, 4'h1);
    rdchk("protect", 9'h140, 8'h0f);
    chk("eec_out", 12'h00f, {4'h0, eeprom_control_out});
    // alu result, then pc low jump
    v = $random(seed);
    cpu_u.alu(v);
    rdchk("acc", 9'h005, v);
    chk("acc_out", {4'h0, v}, {4'h0, accumulator_out});
    cpu_u.access(1'b1, dma_pkg::DMA_OP_FROMACC, 3'h0, 9'h1a1, ~v, rd);
    rdchk("fromacc", 9'h1a1, v);
    cpu_u.advance(300);
    chk("pc_run", 12'h12c, prog_counter);
    cpu_u.access(1'b1, dma_pkg::DMA_OP_BYTE, 3'h0, 9'h006, 8'h34, rd);
    chk("pc_jump", 12'h134, prog_counter);
    chk("dummy", 12'h001, {11'h000, dummy_cycle});
    $display("test datapath done");
    end_of_test();
end
endmodule
`default_nettype wire
